// File: sim/sense_host.sv
// Host model issuing requests on the register port
`timescale 1ns/1ps
module sense_host (
    // Clock
    input  wire logic                 clk,
    // Register port
    output sense_bank_pkg::reg_req_t  req
);
    import sense_bank_pkg::*;
    initial req = '0;
    // Strobe covers one rising edge; released fields show inverted junk, not the last value
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(negedge clk);
        req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge clk);
        req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
endmodule

// File: sim/sense_sampling_config_results_test.sv
// Self-checking bench of the sense register bank
`timescale 1ns/1ps
module sense_sampling_config_results_test;
    import sense_bank_pkg::*;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    reg_req_t          req;
    logic [7:0]        rdata;
    source_cfg_t       source_cfg;
    sense_cfg_t        ch1_sense_cfg;
    sense_cfg_t        ch2_sense_cfg;
    logic [1:0][11:0]  sense_sample = '0;
    logic [1:0]        sense_valid = '0;
    logic [1:0][11:0]  sense_value;
    logic [1:0]        result_update;
    logic [7:0]        solo_rdata;
    source_cfg_t       solo_source_cfg;
    sense_cfg_t        solo_ch2_cfg;
    logic [1:0][11:0]  solo_value;
    logic [7:0]        rd_q[$];
    logic [12:0]       res_q[$];
    logic [1:0][11:0]  cur = '0;
    logic [31:0]       seed = 32'hc09d71a5;
    logic [7:0]        d;
    logic [7:0]        rst_exp [9] = '{8'h00, 8'h00, 8'h53, 8'h53, 8'h00, 8'h00, 8'h00,
                                       8'h00, 8'h00};
    int                miscompares = 0;
    int                tests_run = 0;

    always #20 clk = ~clk;

    sense_host i_sense_host (.clk(clk), .req(req));
    sense_sampling_config_results i_sense_sampling_config_results (
        .clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .source_cfg(source_cfg),
        .ch1_sense_cfg(ch1_sense_cfg), .ch2_sense_cfg(ch2_sense_cfg),
        .sense_sample(sense_sample), .sense_valid(sense_valid),
        .sense_value(sense_value), .result_update(result_update));

    // One-channel build shares the stimulus; its channel 2 must stay silent
    if (1'b1)
    begin : g_single
        sense_sampling_config_results #(.CHANNELS(1)) i_sense_sampling_config_results (
            .clk(clk), .nrst(nrst), .req(req), .rdata(solo_rdata),
            .source_cfg(solo_source_cfg), .ch1_sense_cfg(), .ch2_sense_cfg(solo_ch2_cfg),
            .sense_sample(sense_sample), .sense_valid(sense_valid),
            .sense_value(solo_value), .result_update());
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic test_done;
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        i_sense_host.access(a, 1'b0, 8'h00);
    endtask

    // Back-to-back samples; expected mean is the floor of the signed sum over 2**k
    task automatic batch(input int c, input int k);
        int          sum;
        logic [11:0] s;
        sum = 0;
        for (int i = 0; i < (1 << k); i++)
        begin
            @(negedge clk);
            seed = next_rand(seed);
            s = seed[11:0];
            sum += $signed(s);
            sense_sample[c] = s;
            sense_valid[c] = 1'b1;
        end
        cur[c] = 12'(sum >>> k);
        res_q.push_back({c[0], cur[c]});
        @(negedge clk);
        sense_valid = '0;
        sense_sample = ~sense_sample;
    endtask

    // Read data is due the cycle after the taking edge
    always @(posedge clk)
    begin
        if (req.rd === 1'b1)
        begin
            @(negedge clk);
            check({8'h00, rdata}, {8'h00, rd_q.size() ? rd_q.pop_front() : 8'hxx});
        end
    end

    // An update pulse with no batch pending is a mismatch as well
    always @(negedge clk)
        for (int c = 0; c < 2; c++)
            if (result_update[c] === 1'b1)
                check({3'h0, c[0], sense_value[c]},
                      {3'h0, res_q.size() ? res_q.pop_front() : 13'hxxxx});

    initial
    begin
        #400000;
        miscompares++;
        test_done();
    end

    initial
    begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 9; i++)
            rd(8'h09 + 8'(i), rst_exp[i]);
        for (int i = 0; i < 4; i++)
        begin
            seed = next_rand(seed);
            i_sense_host.access(8'h0a, 1'b1, seed[7:0]);
            check({8'h00, source_cfg}, {8'h00, seed[7:0]});
            check({8'h00, solo_source_cfg}, {12'h000, seed[3:0]});
            rd(8'h0a, seed[7:0]);
            check({8'h00, solo_rdata}, {12'h000, seed[3:0]});
        end
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < 4; k++)
            begin
                seed = next_rand(seed);
                d = {seed[7:4], 2'(k), seed[1:0]};
                i_sense_host.access(8'h0b + 8'(c), 1'b1, d);
                check({8'h00, c ? ch2_sense_cfg : ch1_sense_cfg}, {8'h00, d & 8'h7f});
                rd(8'h0b + 8'(c), d & 8'h7f);
                batch(c, k);
                rd(8'h0d + 8'(2 * c), cur[c][11:4]);
                rd(8'h0e + 8'(2 * c), {cur[c][3:0], 4'h0});
            end
        i_sense_host.access(8'h0d, 1'b1, 8'hff);
        rd(8'h0d, cur[0][11:4]);
        // The shadow is shared, so this low byte still belongs to channel 1
        rd(8'h10, {cur[0][3:0], 4'h0});
        rd(8'h0f, cur[1][11:4]);
        rd(8'h10, {cur[1][3:0], 4'h0});
        rd(8'h0c, d & 8'h7f);
        check({8'h00, solo_rdata}, 16'h0000);
        check({8'h00, solo_ch2_cfg}, 16'h0000);
        check({4'h0, solo_value[0]}, {4'h0, cur[0]});
        check({4'h0, solo_value[1]}, 16'h0000);
        repeat (4) @(negedge clk);
        test_done();
    end
endmodule

// File: verilog/sense_bank_pkg.sv
// Types shared by the sense register bank
package sense_bank_pkg;
    typedef struct packed {
        logic [1:0] ch2_src_sample_time;
        logic [1:0] ch2_src_avg_count;
        logic [1:0] ch1_src_sample_time;
        logic [1:0] ch1_src_avg_count;
    } source_cfg_t;
    typedef struct packed {
        logic       spare;
        logic [2:0] sample_time;
        logic [1:0] avg_count;
        logic [1:0] full_range;
    } sense_cfg_t;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// File: verilog/sense_bank_regs.svh
// Register offsets, field positions, reset values and counts of the sense register bank
`ifndef SENSE_BANK_REGS_SVH
`define SENSE_BANK_REGS_SVH
`define SRC_CFG_OFS        8'h0a
`define CH1_SENSE_CFG_OFS  8'h0b
`define CH2_SENSE_CFG_OFS  8'h0c
`define CH1_RES_HI_OFS     8'h0d
`define CH1_RES_LO_OFS     8'h0e
`define CH2_RES_HI_OFS     8'h0f
`define CH2_RES_LO_OFS     8'h10
`define SRC_CFG_RST        8'h00
`define SENSE_CFG_RST      8'h53
`define SENSE_CFG_MASK     8'h7f
`define RES_RST            12'h000
`define RES_LSB            4
`define RES_PAD            4'h0
`define AVG_MAX_LOG2       3
`endif

// File: verilog/sense_sampling_config_results.sv
// Sampling configuration and shunt-voltage result registers for one or two channels
// Notes on behaviour
// - Bits 7-6 pick channel 2 source sample time
// - Bits 5-4 pick channel 2 source averaging
// - Bits 3-2 pick channel 1 source sample time
// - Bits 1-0 pick channel 1 source averaging
// - Channel 1 sense bits 6-4 set sample time
// - Channel 1 sense bits 3-2 set averaging
// - Channel 1 sense bits 1-0 set range
// - Channel 2 sense bits 6-4 set sample time
// - Channel 2 sense bits 3-2 set averaging
// - Channel 2 sense bits 1-0 set range
// - Channel 1 result sits in bits 15-4
// - Channel 2 result sits in bits 15-4
// - Result bits 3-0 always read zero
// - Single channel: channel 2 fields read zero, except its result low byte, which reads the shared low-byte shadow
`timescale 1ns/1ps
`include "sense_bank_regs.svh"
module sense_sampling_config_results #(
    parameter int CHANNELS = 2,
    parameter int SAMPLE_W = 12
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      nrst,
    // Register port from the management bus engine
    input  wire sense_bank_pkg::reg_req_t  req,
    output logic [7:0]                     rdata,
    // Settings to the conversion engine
    output sense_bank_pkg::source_cfg_t    source_cfg,
    output sense_bank_pkg::sense_cfg_t     ch1_sense_cfg,
    output sense_bank_pkg::sense_cfg_t     ch2_sense_cfg,
    // Raw shunt samples from the conversion engine
    input  wire logic [1:0][SAMPLE_W-1:0]  sense_sample,
    input  wire logic [1:0]                sense_valid,
    // Published results, bit 0 is channel 1
    output logic [1:0][SAMPLE_W-1:0]       sense_value,
    output logic [1:0]                     result_update
);
    import sense_bank_pkg::*;

    localparam int ACC_W = SAMPLE_W + `AVG_MAX_LOG2;

    if (CHANNELS < 1 || CHANNELS > 2 || SAMPLE_W != 12)
    begin : g_bad_params
        $error("sense bank: CHANNELS must be 1 or 2 and SAMPLE_W 12");
    end

    sense_cfg_t      sense_cfg [2];
    logic [1:0]      cfg_wr;
    logic [7:0]      lo_shadow;
    logic [7:0]      next_rdata;

    assign ch1_sense_cfg = sense_cfg[0];
    assign ch2_sense_cfg = sense_cfg[1];
    assign cfg_wr[0] = req.wr && req.addr == `CH1_SENSE_CFG_OFS;
    // A one-channel build drops channel 2 writes, so its fields never move
    assign cfg_wr[1] = req.wr && req.addr == `CH2_SENSE_CFG_OFS && CHANNELS == 2;

    // Source sampling configuration; channel 2 half stays zero without channel 2
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            source_cfg <= `SRC_CFG_RST;
        else if (req.wr && req.addr == `SRC_CFG_OFS)
        begin
            source_cfg.ch1_src_sample_time <= req.wdata[3:2];
            source_cfg.ch1_src_avg_count   <= req.wdata[1:0];
            if (CHANNELS == 2)
            begin
                source_cfg.ch2_src_sample_time <= req.wdata[7:6];
                source_cfg.ch2_src_avg_count   <= req.wdata[5:4];
            end
        end
    end

    // Per channel sense configuration and averaging
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_ch
            logic signed [ACC_W-1:0] acc;
            logic [`AVG_MAX_LOG2-1:0] cnt;
            logic [`AVG_MAX_LOG2-1:0] last;
            logic signed [ACC_W-1:0] sum;
            logic signed [ACC_W-1:0] mean;

            assign last = `AVG_MAX_LOG2'((1 << sense_cfg[ch].avg_count) - 1);
            assign sum  = acc + ACC_W'(signed'(sense_sample[ch]));
            assign mean = sum >>> sense_cfg[ch].avg_count;

            if (ch == 0 || CHANNELS == 2)
            begin : g_live
                // Reset value has bit 7 clear, so the mask keeps it unimplemented
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                        sense_cfg[ch] <= `SENSE_CFG_RST;
                    else if (cfg_wr[ch])
                        sense_cfg[ch] <= req.wdata & `SENSE_CFG_MASK;
                end

                // A new averaging setting restarts the batch, so no stale partial sum leaks out
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                    begin
                        acc           <= '0;
                        cnt           <= '0;
                        sense_value[ch]   <= `RES_RST;
                        result_update[ch] <= 1'b0;
                    end
                    else
                    begin
                        result_update[ch] <= 1'b0;
                        if (cfg_wr[ch])
                        begin
                            acc <= '0;
                            cnt <= '0;
                        end
                        else if (sense_valid[ch])
                        begin
                            if (cnt == last)
                            begin
                                sense_value[ch]   <= mean[SAMPLE_W-1:0];
                                result_update[ch] <= 1'b1;
                                acc <= '0;
                                cnt <= '0;
                            end
                            else
                            begin
                                acc <= sum;
                                cnt <= cnt + 1'b1;
                            end
                        end
                    end
                end

                // Batch bookkeeping, checked per live channel
                a_batch_restart: assert property (@(posedge clk) disable iff (!nrst)
                    cfg_wr[ch] |=> cnt == '0 && acc == '0 && !result_update[ch])
                    else $error("partial batch survived a configuration write");
                a_count_bound: assert property (@(posedge clk) disable iff (!nrst)
                    cnt <= last)
                    else $error("batch counter ran past the averaging length");
                a_pair_mean: assert property (@(posedge clk) disable iff (!nrst)
                    sense_valid[ch] && !cfg_wr[ch] && cnt == '0 &&
                    sense_cfg[ch].avg_count == 2'h1 ##1 sense_valid[ch] && !cfg_wr[ch]
                    |=> result_update[ch] && sense_value[ch] == SAMPLE_W'((
                        ACC_W'(signed'($past(sense_sample[ch], 2))) +
                        ACC_W'(signed'($past(sense_sample[ch])))) >>> 1))
                    else $error("two-sample mean not published");
            end
            else
            begin : g_absent
                // Absent channel: fixed zeros, its inputs are ignored
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                    begin
                        sense_cfg[ch]     <= '0;
                        acc               <= '0;
                        cnt               <= '0;
                        sense_value[ch]   <= `RES_RST;
                        result_update[ch] <= 1'b0;
                    end
                    else
                    begin
                        sense_cfg[ch]     <= '0;
                        acc               <= '0;
                        cnt               <= '0;
                        sense_value[ch]   <= `RES_RST;
                        result_update[ch] <= 1'b0;
                    end
                end

                a_absent_quiet: assert property (@(posedge clk) disable iff (!nrst)
                    !result_update[ch] && sense_value[ch] == '0 && sense_cfg[ch] == '0)
                    else $error("absent channel shows activity");
            end
        end
    endgenerate

    // Read mux; both low bytes read one shadow, snapped when either high byte is read, so a
    // high-then-low read pair of one channel never mixes two results
    always_comb
    begin
        case (req.addr)
            `SRC_CFG_OFS:       next_rdata = source_cfg;
            `CH1_SENSE_CFG_OFS: next_rdata = sense_cfg[0];
            `CH2_SENSE_CFG_OFS: next_rdata = sense_cfg[1];
            `CH1_RES_HI_OFS:    next_rdata = sense_value[0][SAMPLE_W-1:`RES_LSB];
            `CH2_RES_HI_OFS:    next_rdata = sense_value[1][SAMPLE_W-1:`RES_LSB];
            `CH1_RES_LO_OFS,
            `CH2_RES_LO_OFS:    next_rdata = lo_shadow;
            default:            next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= 8'h00;
        else if (req.rd)
            rdata <= next_rdata;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lo_shadow <= 8'h00;
        else if (req.rd && req.addr == `CH1_RES_HI_OFS)
            lo_shadow <= {sense_value[0][`RES_LSB-1:0], `RES_PAD};
        else if (req.rd && req.addr == `CH2_RES_HI_OFS)
            lo_shadow <= {sense_value[1][`RES_LSB-1:0], `RES_PAD};
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_src_cfg_ch1: assert property (
        req.wr && req.addr == `SRC_CFG_OFS |=> source_cfg[3:0] == $past(req.wdata[3:0]))
        else $error("channel 1 source fields not taken from write");
    a_src_cfg_ch2: assert property (
        req.wr && req.addr == `SRC_CFG_OFS |=>
            source_cfg[7:4] == (CHANNELS == 2 ? $past(req.wdata[7:4]) : 4'h0))
        else $error("channel 2 source fields wrong after write");
    a_src_avg_hold: assert property (
        !(req.wr && req.addr == `SRC_CFG_OFS) |=> $stable(source_cfg))
        else $error("source configuration changed without a write");
    a_sense1_cfg: assert property (
        cfg_wr[0] |=> ch1_sense_cfg == ($past(req.wdata) & `SENSE_CFG_MASK))
        else $error("channel 1 sense configuration not written");
    a_sense2_cfg: assert property (
        req.wr && req.addr == `CH2_SENSE_CFG_OFS |=>
            ch2_sense_cfg == (CHANNELS == 2 ? ($past(req.wdata) & `SENSE_CFG_MASK) : 8'h00))
        else $error("channel 2 sense configuration wrong");
    a_res_hi_read: assert property (
        req.rd && req.addr == `CH1_RES_HI_OFS |=> rdata == $past(sense_value[0][11:4]))
        else $error("channel 1 result high byte wrong");
    a_res_lo_zero: assert property (
        req.rd && (req.addr == `CH1_RES_LO_OFS || req.addr == `CH2_RES_LO_OFS)
            |=> rdata[3:0] == 4'h0)
        else $error("result low nibble not zero");
    a_single_zero: assert property (
        CHANNELS == 1 |-> sense_value[1] == 12'h000 && ch2_sense_cfg == 8'h00)
        else $error("absent channel 2 not zero");
    a_full_batch: assert property (
        result_update[0] |-> $past(sense_valid[0]) && !$past(cfg_wr[0]))
        else $error("channel 1 result updated without a finished batch");
    a_value_hold: assert property (
        !result_update[0] |-> $stable(sense_value[0]))
        else $error("channel 1 result moved between batches");
    a_avg_one: assert property (
        sense_valid[0] && !cfg_wr[0] && ch1_sense_cfg.avg_count == 2'h0
            |=> result_update[0] && sense_value[0] == $past(sense_sample[0]))
        else $error("single-sample average not published next cycle");

    // Source configuration fields, and configuration held across result-register writes
    a_src_ch1_avg: assert property (
        req.wr && req.addr == `SRC_CFG_OFS
            |=> source_cfg.ch1_src_avg_count == $past(req.wdata[1:0]))
        else $error("channel 1 source averaging not taken from write");
    a_src_ch2_avg: assert property (
        req.wr && req.addr == `SRC_CFG_OFS |=> source_cfg.ch2_src_avg_count ==
            (CHANNELS == 2 ? $past(req.wdata[5:4]) : 2'h0))
        else $error("channel 2 source averaging wrong after write");
    a_single_src: assert property (
        CHANNELS == 1 |-> source_cfg[7:4] == 4'h0)
        else $error("absent channel 2 source fields not zero");
    a_result_ro: assert property (
        req.wr && req.addr >= `CH1_RES_HI_OFS && req.addr <= `CH2_RES_LO_OFS
            |=> $stable(source_cfg) && $stable(ch1_sense_cfg) && $stable(ch2_sense_cfg))
        else $error("write to a result register changed the configuration");

    // Sense configuration fields
    a_sense1_avg: assert property (
        cfg_wr[0] |=> ch1_sense_cfg.avg_count == $past(req.wdata[3:2]))
        else $error("channel 1 sense averaging not written");
    a_sense1_range: assert property (
        cfg_wr[0] |=> ch1_sense_cfg.full_range == $past(req.wdata[1:0]))
        else $error("channel 1 sense range not written");
    a_sense2_avg: assert property (
        req.wr && req.addr == `CH2_SENSE_CFG_OFS |=> ch2_sense_cfg.avg_count ==
            (CHANNELS == 2 ? $past(req.wdata[3:2]) : 2'h0))
        else $error("channel 2 sense averaging wrong");
    a_sense2_range: assert property (
        req.wr && req.addr == `CH2_SENSE_CFG_OFS |=> ch2_sense_cfg.full_range ==
            (CHANNELS == 2 ? $past(req.wdata[1:0]) : 2'h0))
        else $error("channel 2 sense range wrong");
    a_spare_zero: assert property (
        !ch1_sense_cfg.spare && !ch2_sense_cfg.spare)
        else $error("unimplemented sense configuration bit set");
    a_sense1_hold: assert property (
        !cfg_wr[0] |=> $stable(ch1_sense_cfg))
        else $error("channel 1 sense configuration changed without a write");
    a_sense2_hold: assert property (
        !cfg_wr[1] |=> $stable(ch2_sense_cfg))
        else $error("channel 2 sense configuration changed without a write");

    // Result reads; the low byte comes from the shadow of the last high-byte read
    a_ch2_hi_read: assert property (
        req.rd && req.addr == `CH2_RES_HI_OFS |=> rdata == $past(sense_value[1][11:4]))
        else $error("channel 2 result high byte wrong");
    a_ch1_lo_read: assert property (
        req.rd && req.addr == `CH1_RES_HI_OFS ##1 !req.rd
            ##1 req.rd && req.addr == `CH1_RES_LO_OFS
            |=> rdata == {$past(sense_value[0][3:0], 3), `RES_PAD})
        else $error("channel 1 result low byte wrong");
    a_ch2_lo_read: assert property (
        req.rd && req.addr == `CH2_RES_HI_OFS ##1 !req.rd
            ##1 req.rd && req.addr == `CH2_RES_LO_OFS
            |=> rdata == {$past(sense_value[1][3:0], 3), `RES_PAD})
        else $error("channel 2 result low byte wrong");
    a_rdata_hold: assert property (
        !req.rd |=> $stable(rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        req.rd && req.addr > `CH2_RES_LO_OFS |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // Channel 2 batches and publication without samples
    a_ch2_full_batch: assert property (
        result_update[1] |-> $past(sense_valid[1]) && !$past(cfg_wr[1]))
        else $error("channel 2 result updated without a finished batch");
    a_ch2_value_hold: assert property (
        !result_update[1] |-> $stable(sense_value[1]))
        else $error("channel 2 result moved between batches");
    a_ch1_needs_sample: assert property (
        !sense_valid[0] |=> !result_update[0])
        else $error("channel 1 result published without a sample");
    a_ch2_needs_sample: assert property (
        !sense_valid[1] |=> !result_update[1])
        else $error("channel 2 result published without a sample");
    a_ch2_avg_one: assert property (
        sense_valid[1] && !cfg_wr[1] && ch2_sense_cfg.avg_count == 2'h0 |=>
            result_update[1] == (CHANNELS == 2) &&
            sense_value[1] == (CHANNELS == 2 ? $past(sense_sample[1]) : 12'h000))
        else $error("channel 2 single-sample average wrong");

    c_ch1_update:  cover property (result_update[0]);
    c_ch2_update:  cover property (result_update[1]);
    c_pair_read:   cover property (req.rd && req.addr == `CH1_RES_HI_OFS
                                   ##1 !req.rd
                                   ##1 req.rd && req.addr == `CH1_RES_LO_OFS);
    c_avg_eight:   cover property (result_update[0] && ch1_sense_cfg.avg_count == 2'h3);
    c_ch2_eight:   cover property (result_update[1] && ch2_sense_cfg.avg_count == 2'h3);
endmodule
